// ---- rtl/reader_irq_map.svh ----
// register indices, field positions, reset values and timing counts of the
// interrupt mask and general purpose timeout block; included by its bare name
`ifndef READER_IRQ_MAP_SVH
`define READER_IRQ_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_TIMER_CTRL     6'h11
`define IDX_GP_TIMEOUT_HI  6'h12
`define IDX_GP_TIMEOUT_LO  6'h13
`define IDX_MAIN_MASK      6'h14
`define IDX_TF_MASK        6'h15
`define IDX_EW_MASK        6'h16
`define IDX_MAIN_FLAGS     6'h17
`define IDX_TF_FLAGS       6'h18
`define IDX_EW_FLAGS       6'h19
`define IDX_COMMAND        6'h1E
`define IDX_GP_STATUS      6'h1F

// field positions
`define MAIN_CLR_MSB       7
`define MAIN_CLR_LSB       2
`define MAIN_TIM_BIT       1
`define MAIN_ERR_BIT       0
`define TRIG_MSB           7
`define TRIG_LSB           5
`define CMD_SET_DEFAULT    0
`define CMD_START_GP       1
`define TF_GP_EXPIRY_BIT   5

// trigger source codes
`define TRIG_DIRECT        3'h0
`define TRIG_RX_END        3'h1
`define TRIG_RX_START      3'h2
`define TRIG_TX_END        3'h3

// reset values
`define MASK_RESET         8'h00
`define FLAGS_RESET        8'h00
`define TRIG_RESET         3'h0
`define GP_TIMEOUT_RESET   16'h0000

// timing: one timeout step, and the clock period it is counted in
`define GP_STEP_NS         590
`define CLK_PERIOD_NS      25
`define GP_STEP_CYCLES     ((`GP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/reader_irq_mask_and_gp_timeout.sv ----
// interrupt flags, masks and general purpose timeout timer behind an apb slave
// assumes event inputs are one-cycle pulses from logic on sys_clk
//
// What this block does
// (R1) 16-bit timeout, high 0x12, low 0x13, 8/fc steps
// (R2) timeout spans one step to about 39.3 ms
// (R3) main mask bits 7..2 suppress six main sources
// (R4) timer-field mask bits suppress eight detail sources
// (R5) error-wakeup mask bits suppress eight detail sources
// (R6) masks and timeout reload at reset, set-default
// (R7) main flags zero after reset and set-default
// (R8) main read clears 7..2; 1..0 via detail
// (R9) main bit 1 summarises timer-field detail flags
// (R10) main bit 0 summarises error-wakeup detail flags
// (R11) main bit 7 set when oscillator stable
// (R12) main bit 6 set on fifo water level
// (R13) bits 5..2: rx start, rx end, tx end, collision
// (R14) trigger field selects timer start event
// (R15) irq high while any unmasked flag set
// (R16) timer counts steps then sets expiry flag
`timescale 1ns/1ps
`include "reader_irq_map.svh"

module reader_irq_mask_and_gp_timeout
  import reader_irq_pkg::*;
#(
  parameter int STEP_CYCLES = `GP_STEP_CYCLES
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  input  main_events_t      mainEvents,
  input  wire logic [7:0]   timerFieldEvents,
  input  wire logic [7:0]   errorWakeEvents,
  input  wire logic         fieldMode,
  output logic              irq,
  output logic              gpFieldOff
);

  localparam int SW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);

  // software visible state
  logic [7:0]     gpTimeoutHigh;
  logic [7:0]     gpTimeoutLow;
  logic [2:0]     trigSource;
  logic [7:0]     mainMask;
  logic [7:0]     timerFieldMask;
  logic [7:0]     errorWakeMask;
  logic [7:2]     mainFlags;
  logic [7:0]     timerFieldFlags;
  logic [7:0]     errorWakeFlags;

  // timer state
  gp_state_t      gpState;
  logic [SW-1:0]  stepCnt;
  logic [15:0]    stepsLeft;
  logic           gpExpire;

  // bus decode
  logic [5:0]     regIdx;
  logic           aligned;
  logic           mapped;
  logic           setupPhase;
  logic           rdDone;
  logic           wrDone;
  logic [7:0]     readMux;
  logic           setDefault;
  logic           startCmd;
  logic           gpTrigger;
  logic [15:0]    gpTimeout;
  logic [7:0]     mainView;
  logic [7:2]     mainClr;
  logic [7:0]     tfClr;
  logic [7:0]     ewClr;
  logic [7:0]     tfSet;

  assign regIdx     = paddr[7:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign setupPhase = psel & ~penable;
  assign rdDone     = psel & penable & ~pwrite;
  assign wrDone     = psel & penable & pwrite;
  assign gpTimeout  = {gpTimeoutHigh, gpTimeoutLow}; // R1

  // main view: bits 1 and 0 follow the detail registers
  assign mainView = {mainFlags,
                     |timerFieldFlags,  // R9
                     |errorWakeFlags};  // R10

  // address decode and read data selection
  always_comb begin
    mapped  = aligned;
    readMux = 8'h00;
    case (regIdx)
      `IDX_TIMER_CTRL:    readMux[`TRIG_MSB:`TRIG_LSB] = trigSource;
      `IDX_GP_TIMEOUT_HI: readMux = gpTimeoutHigh;
      `IDX_GP_TIMEOUT_LO: readMux = gpTimeoutLow;
      `IDX_MAIN_MASK:     readMux = mainMask;
      `IDX_TF_MASK:       readMux = timerFieldMask;
      `IDX_EW_MASK:       readMux = errorWakeMask;
      `IDX_MAIN_FLAGS:    readMux = mainView;
      `IDX_TF_FLAGS:      readMux = timerFieldFlags;
      `IDX_EW_FLAGS:      readMux = errorWakeFlags;
      `IDX_COMMAND:       readMux = 8'h00;
      `IDX_GP_STATUS:     readMux = {7'h00, (gpState == GP_RUN)};
      default:            mapped  = 1'b0;
    endcase
  end

  // zero wait state slave; error on unmapped or unaligned access
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;

  // read data captured in the setup cycle, held through the access
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= {24'h00_0000, (mapped ? readMux : 8'h00)};
    end
  end

  // command strobes act at the access edge of a command write
  assign setDefault = wrDone & mapped & (regIdx == `IDX_COMMAND)
                      & pwdata[`CMD_SET_DEFAULT];
  assign startCmd   = wrDone & mapped & (regIdx == `IDX_COMMAND)
                      & pwdata[`CMD_START_GP] & ~pwdata[`CMD_SET_DEFAULT];

  // clear vectors: a read clears the bits it returned, a write of ones
  // clears those bits, main bits 1..0 excepted; events caught later survive
  always_comb begin
    mainClr = '0;
    tfClr   = 8'h00;
    ewClr   = 8'h00;
    if (psel && penable && mapped) begin
      case (regIdx)
        `IDX_MAIN_FLAGS: mainClr = pwrite ? pwdata[`MAIN_CLR_MSB:`MAIN_CLR_LSB]
                                          : prdata[`MAIN_CLR_MSB:`MAIN_CLR_LSB]; // R8
        `IDX_TF_FLAGS:   tfClr   = pwrite ? pwdata[7:0] : prdata[7:0]; // R8
        `IDX_EW_FLAGS:   ewClr   = pwrite ? pwdata[7:0] : prdata[7:0]; // R8
        default: begin
          mainClr = '0;
        end
      endcase
    end
  end

  // timeout pair and trigger field
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gpTimeoutHigh <= 8'(`GP_TIMEOUT_RESET >> 8);
      gpTimeoutLow  <= 8'(`GP_TIMEOUT_RESET);
      trigSource    <= `TRIG_RESET;
    end else if (setDefault) begin
      gpTimeoutHigh <= 8'(`GP_TIMEOUT_RESET >> 8);     // R6
      gpTimeoutLow  <= 8'(`GP_TIMEOUT_RESET);          // R6
      trigSource    <= `TRIG_RESET;
    end else if (wrDone && mapped) begin
      case (regIdx)
        `IDX_GP_TIMEOUT_HI: gpTimeoutHigh <= pwdata[7:0]; // R1
        `IDX_GP_TIMEOUT_LO: gpTimeoutLow  <= pwdata[7:0]; // R1
        `IDX_TIMER_CTRL:    trigSource    <= pwdata[`TRIG_MSB:`TRIG_LSB]; // R14
        default: begin
          trigSource <= trigSource;
        end
      endcase
    end
  end

  // mask registers; a one suppresses the source
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mainMask       <= `MASK_RESET;
      timerFieldMask <= `MASK_RESET;
      errorWakeMask  <= `MASK_RESET;
    end else if (setDefault) begin
      mainMask       <= `MASK_RESET; // R6
      timerFieldMask <= `MASK_RESET; // R6
      errorWakeMask  <= `MASK_RESET; // R6
    end else if (wrDone && mapped) begin
      case (regIdx)
        `IDX_MAIN_MASK: mainMask       <= {pwdata[7:2], 2'b00}; // R3
        `IDX_TF_MASK:   timerFieldMask <= pwdata[7:0];          // R4
        `IDX_EW_MASK:   errorWakeMask  <= pwdata[7:0];          // R5
        default: begin
          mainMask <= mainMask;
        end
      endcase
    end
  end

  // main flags 7..2: osc, water level, rx start, rx end, tx end, collision
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mainFlags <= 6'(`FLAGS_RESET >> 2);
    end else if (setDefault) begin
      mainFlags <= 6'(`FLAGS_RESET >> 2); // R7
    end else begin
      mainFlags <= (mainFlags & ~mainClr) | mainEvents; // R11 R12 R13
    end
  end

  // timer expiry joins the timer-field events
  always_comb begin
    tfSet = timerFieldEvents;
    tfSet[`TF_GP_EXPIRY_BIT] = timerFieldEvents[`TF_GP_EXPIRY_BIT] | gpExpire; // R16
  end

  // detail flags, one sticky bit each; a set wins over a clear
  for (genvar i = 0; i < 8; i++) begin : g_detail
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        timerFieldFlags[i] <= 1'b0;
        errorWakeFlags[i]  <= 1'b0;
      end else if (setDefault) begin
        timerFieldFlags[i] <= 1'b0;
        errorWakeFlags[i]  <= 1'b0;
      end else begin
        timerFieldFlags[i] <= (timerFieldFlags[i] & ~tfClr[i]) | tfSet[i];          // R9
        errorWakeFlags[i]  <= (errorWakeFlags[i] & ~ewClr[i]) | errorWakeEvents[i]; // R10
      end
    end
  end

  // interrupt request: any flag whose mask bit is zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(mainFlags & ~mainMask[7:2])          // R15 R3
           | |(timerFieldFlags & ~timerFieldMask)   // R15 R4
           | |(errorWakeFlags & ~errorWakeMask);    // R15 R5
    end
  end

  // start event chosen by the trigger field; direct start always works
  always_comb begin
    case (trigSource)
      `TRIG_RX_END:   gpTrigger = startCmd | mainEvents.rxEnd;             // R14
      `TRIG_RX_START: gpTrigger = startCmd | mainEvents.rxStart;           // R14
      `TRIG_TX_END:   gpTrigger = startCmd | (mainEvents.txEnd & fieldMode); // R14
      default:        gpTrigger = startCmd;                                // R14
    endcase
  end

  // timer: stepsLeft steps of STEP_CYCLES clocks each; a trigger with a non-zero timeout restarts it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gpState   <= GP_IDLE;
      stepCnt   <= '0;
      stepsLeft <= 16'h0000;
      gpExpire  <= 1'b0;
    end else if (setDefault) begin
      gpState   <= GP_IDLE;
      stepCnt   <= '0;
      stepsLeft <= 16'h0000;
      gpExpire  <= 1'b0;
    end else begin
      gpExpire <= 1'b0;
      case (gpState)
        GP_IDLE: begin
          if (gpTrigger && gpTimeout != 16'h0000) begin
            gpState   <= GP_RUN;
            stepCnt   <= '0;
            stepsLeft <= gpTimeout; // R2
          end
        end
        GP_RUN: begin
          if (gpTrigger && gpTimeout != 16'h0000) begin
            stepCnt   <= '0;
            stepsLeft <= gpTimeout;
          end else if (stepCnt != STEP_LAST) begin
            stepCnt <= stepCnt + 1'b1; // R1
          end else begin
            stepCnt <= '0;
            if (stepsLeft == 16'h0001) begin
              gpState  <= GP_IDLE;
              gpExpire <= 1'b1; // R16
            end else begin
              stepsLeft <= stepsLeft - 16'h0001; // R16
            end
          end
        end
        default: begin
          gpState <= GP_IDLE;
        end
      endcase
    end
  end

  // field switch-off request when the timer ends in tx-end mode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gpFieldOff <= 1'b0;
    end else begin
      gpFieldOff <= gpExpire & (trigSource == `TRIG_TX_END);
    end
  end

endmodule // reader_irq_mask_and_gp_timeout

// ---- rtl/reader_irq_pkg.sv ----
// types shared by the interrupt mask and general purpose timeout block
// assumes nothing beyond a SystemVerilog compiler
package reader_irq_pkg;

  // main event pulses, in the order of main flag bits 7 down to 2
  typedef struct packed {
    logic oscStable;
    logic fifoLevel;
    logic rxStart;
    logic rxEnd;
    logic txEnd;
    logic bitCollision;
  } main_events_t;

  // general purpose timer states, one-hot
  typedef enum logic [1:0] {
    GP_IDLE = 2'b01,
    GP_RUN  = 2'b10
  } gp_state_t;

endpackage

// ---- verification/reader_irq_mask_and_gp_timeout_chk.sv ----
// port assertions for the interrupt mask and timeout block
// assumes zero-wait apb and one-cycle event pulses on sys_clk
`timescale 1ns/1ps
`include "reader_irq_map.svh"
module reader_irq_mask_and_gp_timeout_chk
  import reader_irq_pkg::*;
#(parameter int STEP_CYCLES = 24) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input main_events_t     mainEvents,
  input wire logic [7:0]  timerFieldEvents,
  input wire logic [7:0]  errorWakeEvents,
  input wire logic        fieldMode,
  input wire logic        irq,
  input wire logic        gpFieldOff
);
  localparam logic [7:0] MASK_A = {`IDX_MAIN_MASK, 2'b00};
  localparam logic [7:0] FLAG_A = {`IDX_MAIN_FLAGS, 2'b00};
  localparam logic [7:0] CMD_A  = {`IDX_COMMAND, 2'b00};
  logic       acc;
  logic       wr;
  logic [5:0] mainMask;
  // access phase and write strobe
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  // shadow of the main mask as software last wrote it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) mainMask <= 6'h00;
    else if (wr && paddr == MASK_A) mainMask <= pwdata[7:2];
    else if (wr && paddr == CMD_A && pwdata[0]) mainMask <= 6'h00;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ready_access: assert property (acc |-> pready) else $error("no ready in access");
  a_ready_setup: assert property (psel && !penable |-> !pready && !pslverr)
    else $error("ready in setup");
  a_rdata_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_misalign_err: assert property (acc && !pwrite && paddr[1:0] != 2'h0
    |-> pslverr && prdata == 32'h00000000) else $error("misaligned read accepted");
  a_mask_unused: assert property (acc && !pwrite && paddr == MASK_A |-> prdata[1:0] == 2'h0)
    else $error("unused mask bits read back");
  a_read_clear: assert property (psel && !penable && !pwrite && paddr == FLAG_A
    && 6'(mainEvents) == 6'h00
    ##1 acc && !pwrite && paddr == FLAG_A && 6'(mainEvents) == 6'h00
    ##1 (psel && !penable && !pwrite && paddr == FLAG_A) |=> prdata[7:2] == 6'h00)
    else $error("main flags survive read");
  a_default_irq: assert property (wr && paddr == CMD_A && pwdata[0] |=> ##1 !irq)
    else $error("irq after set-default");
  a_event_irq: assert property ((6'(mainEvents) & ~mainMask) != 6'h00 && !wr |=> ##1 irq)
    else $error("unmasked event without irq");
  a_fieldoff_pulse: assert property (gpFieldOff |=> !gpFieldOff)
    else $error("field off longer than one cycle");
  c_irq_rise: cover property ($rose(irq));
  c_field_off: cover property (gpFieldOff);
  c_main_read: cover property (acc && !pwrite && paddr == FLAG_A ##1 psel && !penable);
endmodule // reader_irq_mask_and_gp_timeout_chk
bind reader_irq_mask_and_gp_timeout reader_irq_mask_and_gp_timeout_chk
  #(.STEP_CYCLES(STEP_CYCLES)) i_reader_irq_mask_and_gp_timeout_chk (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .mainEvents(mainEvents), .timerFieldEvents(timerFieldEvents),
  .errorWakeEvents(errorWakeEvents), .fieldMode(fieldMode), .irq(irq),
  .gpFieldOff(gpFieldOff));

// ---- verification/reader_irq_mask_and_gp_timeout_tb.sv ----
// self-checking bench for the interrupt mask and timeout block
// assumes the design, package and register map header are compiled first
`timescale 1ns/1ps
`include "reader_irq_map.svh"
module reader_irq_mask_and_gp_timeout_tb;
  import reader_irq_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h00000000;
  logic         pready, pslverr, irq, gpFieldOff, er;
  logic [31:0]  prdata;
  main_events_t mainEvents = '0;
  logic [7:0]   timerFieldEvents = 8'h00;
  logic [7:0]   errorWakeEvents = 8'h00;
  logic         fieldMode = 1'b0;
  logic [7:0]   rd;
  logic [5:0]   ev [1:3] = '{6'h04, 6'h08, 6'h02};
  int           bad_count, checked, cyc, foCount;
  reader_irq_mask_and_gp_timeout #(.STEP_CYCLES(2)) i_reader_irq_mask_and_gp_timeout (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .mainEvents(mainEvents), .timerFieldEvents(timerFieldEvents),
    .errorWakeEvents(errorWakeEvents), .fieldMode(fieldMode), .irq(irq),
    .gpFieldOff(gpFieldOff));
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  // cycle ceiling and field-off pulse count
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (gpFieldOff === 1'b1) foCount <= foCount + 1;
    if (cyc == 4000) begin bad_count++; finish_test(); end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; k keeps psel up for a back-to-back setup
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d, input logic k,
                     input logic [1:0] o = 2'b00);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {i, o}; pwdata <= {24'h0, d};
    @(posedge sys_clk); penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata[7:0]; er = pslverr;
    if (!k) begin psel <= 1'b0; penable <= 1'b0; @(posedge sys_clk); end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d); apb(1'b1, i, d, 1'b0); endtask
  task automatic rdc(input logic [5:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00, 1'b0); chk($sformatf("reg %h", i), e, rd);
  endtask
  task automatic pulse(input logic [5:0] m, input logic [7:0] t, input logic [7:0] e);
    mainEvents <= main_events_t'(m); timerFieldEvents <= t; errorWakeEvents <= e;
    @(posedge sys_clk); mainEvents <= '0; timerFieldEvents <= 8'h00; errorWakeEvents <= 8'h00;
    @(posedge sys_clk);
  endtask
  task automatic chkIrq(input logic e);
    @(negedge sys_clk); chk("irq", {7'h0, e}, {7'h0, irq}); @(posedge sys_clk);
  endtask
  task automatic t_regs();
    for (int i = 8'h12; i <= 8'h16; i++) rdc(i[5:0], 8'h00);
    rdc(`IDX_MAIN_FLAGS, 8'h00);
    for (int i = 8'h12; i <= 8'h16; i++) begin
      wr(i[5:0], 8'hA5); rdc(i[5:0], (i == 8'h14) ? 8'hA4 : 8'hA5);
    end
    wr(`IDX_GP_TIMEOUT_HI, 8'hFF); rdc(`IDX_GP_TIMEOUT_HI, 8'hFF);
    apb(1'b0, 6'h20, 8'h00, 1'b0); chk("unmapped err", 8'h01, {7'h0, er});
    apb(1'b0, `IDX_MAIN_MASK, 8'h00, 1'b0, 2'b01); chk("misaligned err", 8'h01, {7'h0, er});
    chk("misaligned data", 8'h00, rd);
    pulse(6'h3F, 8'h01, 8'h01); wr(`IDX_COMMAND, 8'h01); chkIrq(1'b0);
    for (int i = 8'h12; i <= 8'h17; i++) rdc(i[5:0], 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_main();
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 8'h00, 8'h00); chkIrq(1'b1);
      apb(1'b0, `IDX_MAIN_FLAGS, 8'h00, 1'b1); chk("main", 8'h04 << i, rd);
      rdc(`IDX_MAIN_FLAGS, 8'h00); chkIrq(1'b0);
    end
    wr(`IDX_MAIN_MASK, 8'hFC); pulse(6'h3F, 8'h00, 8'h00); chkIrq(1'b0);
    rdc(`IDX_MAIN_FLAGS, 8'hFC); wr(`IDX_MAIN_MASK, 8'h00);
    $display("t_main done");
  endtask
  task automatic t_detail();
    for (int j = 0; j < 2; j++) begin
      pulse(6'h00, j ? 8'h00 : 8'h10, j ? 8'h10 : 8'h00); chkIrq(1'b1);
      rdc(`IDX_MAIN_FLAGS, j ? 8'h01 : 8'h02);
      rdc(`IDX_MAIN_FLAGS, j ? 8'h01 : 8'h02);
      rdc(j ? `IDX_EW_FLAGS : `IDX_TF_FLAGS, 8'h10);
      rdc(`IDX_MAIN_FLAGS, 8'h00); chkIrq(1'b0);
    end
    wr(`IDX_TF_MASK, 8'hFF); wr(`IDX_EW_MASK, 8'hFF);
    pulse(6'h00, 8'hFF, 8'hFF); chkIrq(1'b0);
    rdc(`IDX_TF_FLAGS, 8'hFF); rdc(`IDX_EW_FLAGS, 8'hFF);
    pulse(6'h00, 8'h01, 8'h00); wr(`IDX_TF_FLAGS, 8'h01); rdc(`IDX_TF_FLAGS, 8'h00);
    wr(`IDX_TF_MASK, 8'h00); wr(`IDX_EW_MASK, 8'h00);
    $display("t_detail done");
  endtask
  task automatic t_timer();
    wr(`IDX_GP_TIMEOUT_LO, 8'h03); wr(`IDX_COMMAND, 8'h02);
    repeat (6) @(posedge sys_clk);
    chkIrq(1'b0); chkIrq(1'b1);
    rdc(`IDX_TF_FLAGS, 8'h20); chkIrq(1'b0);
    for (int c = 1; c <= 3; c++) begin
      wr(`IDX_TIMER_CTRL, 8'(c << 5)); fieldMode <= (c == 3);
      pulse(ev[c], 8'h00, 8'h00); repeat (12) @(posedge sys_clk);
      rdc(`IDX_TF_FLAGS, 8'h20);
      rdc(`IDX_MAIN_FLAGS, {ev[c], 2'b00});
    end
    chk("field off pulses", 8'h01, 8'(foCount));
    $display("t_timer done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_regs(); t_main(); t_detail(); t_timer();
    finish_test();
  end
endmodule // reader_irq_mask_and_gp_timeout_tb
